// >>> rtl/iow_pkg.sv
package iow_pkg;
  // io port addresses
  localparam logic [15:0] DISARM_PORT_ADDR = 16'h0080;
  localparam logic [15:0] ARM_PORT_ADDR = 16'h0443;
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_SHORTEST = 4'hf;
  localparam logic [3:0] CODE_NONE = 4'h0;
  // timebase: one tick per step of the interval table
  localparam int CLK_HZ = 40000000;
  localparam int STEP_S = 2;
  localparam int STEP_CYCLES = CLK_HZ * STEP_S;
  localparam int PRE_W = 27;
  localparam int STEP_W = 5;
  // jumper levels
  localparam logic ACTION_RESET = 1'b0;
  localparam logic ACTION_IRQ = 1'b1;
  // reset pulse width in clocks
  localparam logic [7:0] RST_PULSE_CYCLES = 8'h10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_FIRED = 3'h4
  } iow_state_e;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } iow_io_s;

  typedef struct packed {
    iow_state_e state;
    logic [3:0] code;
    logic [PRE_W-1:0] pre;
    logic [STEP_W-1:0] steps;
    logic [7:0] rst_cnt;
    logic irq;
    logic cpu_rst;
  } iow_regs_s;
endpackage : iow_pkg

// >>> rtl/iow_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
module iow_watchdog #(
  parameter int STEP_CYCLES_P = iow_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // isa io write
  input wire iow_pkg::iow_io_s i_io,
  // board jumper, low selects cpu reset
  input wire logic i_timeout_action_select_jumper,
  // timeout actions
  output logic o_cpu_reset,
  output logic o_irq15,
  // state
  output logic o_armed
);

  iow_pkg::iow_regs_s r;
  iow_pkg::iow_regs_s next_r;
  logic arm_wr;
  logic disarm_wr;
  logic step_tick;

  // code c waits (16 - c) two-second steps; code 0 is not a valid level
  function automatic logic [iow_pkg::STEP_W-1:0] steps_for(
    input logic [3:0] code);
    steps_for = iow_pkg::STEP_W'(5'h10 - {1'b0, code});
  endfunction : steps_for

  assign arm_wr = i_io.wr && (i_io.addr == iow_pkg::ARM_PORT_ADDR);
  assign disarm_wr = i_io.wr && (i_io.addr == iow_pkg::DISARM_PORT_ADDR);
  assign step_tick = (r.pre == iow_pkg::PRE_W'(STEP_CYCLES_P - 1));

  always_comb begin
    next_r = r;
    if (r.rst_cnt != 8'h00) begin
      next_r.rst_cnt = r.rst_cnt - 8'h01;
    end
    next_r.cpu_rst = (next_r.rst_cnt != 8'h00);
    case (r.state)
      iow_pkg::ST_IDLE: begin
        next_r.pre = '0;
      end
      iow_pkg::ST_RUN: begin
        next_r.pre = step_tick ? '0 : r.pre + iow_pkg::PRE_W'(1);
        if (step_tick) begin
          next_r.steps = r.steps - iow_pkg::STEP_W'(1);
          if (r.steps == iow_pkg::STEP_W'(1)) begin
            if (i_timeout_action_select_jumper == iow_pkg::ACTION_IRQ) begin
              next_r.state = iow_pkg::ST_FIRED;
              next_r.irq = 1'b1;
            end else begin
              next_r.state = iow_pkg::ST_IDLE;
              next_r.rst_cnt = iow_pkg::RST_PULSE_CYCLES;
              next_r.cpu_rst = 1'b1;
            end
          end
        end
      end
      iow_pkg::ST_FIRED: begin
        next_r.pre = '0;
      end
      default: begin
        next_r.state = iow_pkg::ST_IDLE;
      end
    endcase
    // rearm beats disarm; both restart irq-mode request handling
    if (disarm_wr) begin
      next_r.state = iow_pkg::ST_IDLE;
      next_r.irq = 1'b0;
    end
    if (arm_wr && i_io.data[3:0] != iow_pkg::CODE_NONE) begin
      next_r.state = iow_pkg::ST_RUN;
      next_r.code = i_io.data[3:0];
      next_r.steps = steps_for(i_io.data[3:0]);
      next_r.pre = '0;
      next_r.irq = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r.state <= iow_pkg::ST_IDLE;
      r.code <= iow_pkg::CODE_NONE;
      r.pre <= '0;
      r.steps <= '0;
      r.rst_cnt <= 8'h00;
      r.irq <= 1'b0;
      r.cpu_rst <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign o_cpu_reset = r.cpu_rst;
  assign o_irq15 = r.irq;
  assign o_armed = (r.state == iow_pkg::ST_RUN);

  a_disarm_stops: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    disarm_wr && !arm_wr |=> !o_armed && !o_irq15)
    else $error("disarm write did not stop the watchdog");
  a_arm_starts: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    arm_wr && i_io.data[3:0] != 4'h0 |=> o_armed && r.pre == '0
      && r.steps == 5'(5'h10 - {1'b0, $past(i_io.data[3:0])}))
    else $error("arm write did not load the interval");
  a_shortest_lvl: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    arm_wr && i_io.data[3:0] == 4'hf |=> r.steps == 5'h01)
    else $error("code f is not one step");
  a_irq_holds: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_irq15 && !arm_wr && !disarm_wr |=> o_irq15)
    else $error("irq dropped without software action");
  a_reset_pulse: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_cpu_reset) |-> !o_armed && !o_irq15 ##1 o_cpu_reset[*7])
    else $error("cpu reset pulse too short or left armed");
  a_fire_action: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_armed && step_tick && r.steps == 5'h01 && !arm_wr && !disarm_wr
      |=> (o_irq15 != o_cpu_reset))
    else $error("expiry produced no single action");
  a_no_idle_fire: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !o_armed && !o_irq15 |=> !$rose(o_irq15))
    else $error("irq rose while disarmed");
  a_steps_range: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_armed |-> r.steps >= 5'h01 && r.steps <= 5'h0f)
    else $error("step count outside fifteen levels");

  // pulse counter must start at the full width on the rising edge
  a_pulse_load: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    $rose(o_cpu_reset) |-> r.rst_cnt == iow_pkg::RST_PULSE_CYCLES)
    else $error("cpu reset pulse not loaded with full width");

  // counter steps down by one, so the pulse lasts exactly its width
  a_pulse_count: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    r.rst_cnt != 8'h00 && !o_armed |=> r.rst_cnt == $past(r.rst_cnt) - 8'h01)
    else $error("cpu reset pulse counter skipped a step");

  // output follows the counter, no stray pulse outside it
  a_pulse_level: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    o_cpu_reset == (r.rst_cnt != 8'h00))
    else $error("cpu reset output disagrees with its counter");

  // a zero code is not a level and must leave the setting alone
  a_zero_code_ignored: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    arm_wr && i_io.data[3:0] == 4'h0 |=> r.code == $past(r.code))
    else $error("zero code changed the interval");

  // writes to unrelated ports are not for us
  a_other_addr: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    i_io.wr && !arm_wr && !disarm_wr |=> r.code == $past(r.code))
    else $error("write to another port changed the watchdog");

  // arm and disarm in one cycle: arming wins
  a_arm_wins: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    arm_wr && i_io.data[3:0] != 4'h0 && disarm_wr |=> o_armed)
    else $error("simultaneous disarm beat a valid arm");

  // irq only appears when the jumper selects it
  a_irq_mode_only: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    $rose(o_irq15) |->
      $past(i_timeout_action_select_jumper) == iow_pkg::ACTION_IRQ)
    else $error("irq raised in cpu reset mode");

  // cpu reset only appears when the jumper selects it
  a_rst_mode_only: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    $rose(o_cpu_reset) |->
      $past(i_timeout_action_select_jumper) == iow_pkg::ACTION_RESET)
    else $error("cpu reset raised in irq mode");

  // a valid rearm drops a pending request
  a_irq_clr_arm: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    o_irq15 && arm_wr && i_io.data[3:0] != 4'h0 |=> !o_irq15)
    else $error("rearm did not clear the pending irq");

  // each tick takes exactly one step off the count
  a_step_count: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    o_armed && step_tick && r.steps > 5'h01 && !i_io.wr
      |=> o_armed && r.steps == $past(r.steps) - 5'h01)
    else $error("step count did not advance by one");

  // prescaler sits at zero whenever the count is not running, save the first cycle after a disarm write
  a_pre_idle: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    !o_armed |=> r.pre == '0)
    else $error("prescaler ran while disarmed");

  // fired state always carries the request and never counts
  a_fired_state: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    r.state == iow_pkg::ST_FIRED |-> !o_armed && o_irq15)
    else $error("fired state without a pending irq");

  // while counting there is no request left over
  a_armed_no_irq: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    o_armed |-> !o_irq15)
    else $error("irq pending while the count runs");

  // nothing can start a cpu reset while disarmed
  a_disarm_quiet: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    !o_armed |=> !$rose(o_cpu_reset))
    else $error("cpu reset rose while disarmed");

  // a running count always holds a real level
  a_code_kept: assert property (@(posedge i_mclk)
    disable iff (!i_rstn)
    o_armed |-> r.code != iow_pkg::CODE_NONE)
    else $error("running count holds the zero code");
endmodule : iow_watchdog
`default_nettype wire

// >>> testbench/iow_host.sv
`timescale 1ns/100ps
`default_nettype none
module iow_host (
  // clock
  input wire logic i_mclk,
  // io write toward the watchdog
  output var iow_pkg::iow_io_s o_io
);
  initial o_io = '0;
  // released bus shows inverted leftovers, not the last value
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_io = '{wr: 1'b1, addr: a, data: d};
    @(negedge i_mclk);
    o_io = '{wr: 1'b0, addr: ~a, data: ~d};
  endtask : put
  task automatic refresh(input logic [3:0] c, input int n, input int gap);
    repeat (n) begin
      put(iow_pkg::ARM_PORT_ADDR, {4'h0, c});
      repeat (gap) @(negedge i_mclk);
    end
  endtask : refresh
endmodule : iow_host
`default_nettype wire

// >>> testbench/tb_iow_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
module tb_iow_watchdog;
  localparam int S = 20;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic jmp = 1'b0;
  iow_pkg::iow_io_s io;
  logic rst, irq, armed;
  int err_count = 0;
  int n_checks = 0;
  int n;
  iow_host iow_host_inst (.i_mclk(i_mclk), .o_io(io));
  iow_watchdog #(.STEP_CYCLES_P(S)) iow_watchdog_inst (.i_mclk(i_mclk),
    .i_rstn(i_rstn), .i_io(io), .i_timeout_action_select_jumper(jmp),
    .o_cpu_reset(rst), .o_irq15(irq), .o_armed(armed));
  initial forever #12.5 i_mclk = ~i_mclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // arm, then count cycles until an action shows; +-2 for edge slack
  task automatic fire(input logic [3:0] c);
    int k;
    int e;
    e = (16 - int'(c)) * S;
    iow_host_inst.put(iow_pkg::ARM_PORT_ADDR, {4'ha, c});
    k = 1;
    while (!(rst | irq) && k < 400) begin
      @(negedge i_mclk);
      k++;
    end
    chk(k >= e - 2 && k <= e + 2, 1);
  endtask : fire
  initial begin
    repeat (3) @(negedge i_mclk);
    i_rstn = 1'b1;
    chk({rst, irq, armed}, 0);
    fire(4'hf);
    chk({rst, irq}, 2'b10);
    repeat (20) @(negedge i_mclk);
    chk({rst, armed}, 0);
    jmp = 1'b1;
    for (int c = 15; c >= 1; c--) begin
      fire(c[3:0]);
      chk({rst, irq}, 2'b01);
    end
    iow_host_inst.put(iow_pkg::DISARM_PORT_ADDR, 8'h5a);
    chk({irq, armed}, 0);
    iow_host_inst.put(iow_pkg::ARM_PORT_ADDR, 8'h0f);
    chk(armed, 1);
    repeat (10) @(negedge i_mclk);
    iow_host_inst.put(iow_pkg::DISARM_PORT_ADDR, 8'hc3);
    repeat (40) @(negedge i_mclk);
    chk({irq, armed}, 0);
    iow_host_inst.put(iow_pkg::ARM_PORT_ADDR, 8'h00);
    iow_host_inst.put(16'h0444, 8'h0f);
    chk(armed, 0);
    iow_host_inst.refresh(4'hf, 5, 12);
    chk({irq, armed}, 2'b01);
    end_of_test();
  end
  initial begin
    #200us;
    err_count++;
    end_of_test();
  end
endmodule : tb_iow_watchdog
`default_nettype wire
